// ### hw/dxm_ctl.sv
// Controller end: APB registers launch mode set and self refresh
// commands on the link and enforce waits between them.
// Assumes all_banks_idle comes from the bank tracker on pclk.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
module dxm_ctl #(
  parameter bit X8 = 1'b1,
  parameter int MODE_SET_CYCLE_TIME = dxm_pkg::MODE_SET_CYCLE_TIME_CK,
  parameter int ALIGN = dxm_pkg::ALIGN_CK
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic all_banks_idle,
  output logic read_allowed,
  dxm_if.ctl link
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CMD,
    ST_WAIT
  } dxm_st_t;
  typedef struct packed {
    dxm_st_t st;
    logic [1:0] op;
    logic [dxm_pkg::AW-1:0] first;
    logic ht_sr;
    logic [3:0] wcnt;
    logic [7:0] acnt;
    logic cal_follow;
    logic in_sr;
    logic second_ok;
    logic reject;
    logic [31:0] rdata;
    logic cke;
    logic [3:0] cmd_n;
    logic [1:0] ba;
    logic [dxm_pkg::AW-1:0] addr;
  } dxm_ctl_t;
  dxm_ctl_t st_reg, st_next;
  logic setup;
  logic wr;
  logic mapped;
  logic [dxm_pkg::AW-1:0] first_w;
  logic [31:0] status;

  localparam logic [3:0] CMD_DESEL = 4'hf;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] MODE_SET_CYCLE_TIME_L = 4'(MODE_SET_CYCLE_TIME - 1);
  localparam logic [7:0] ALIGN_L = 8'(ALIGN);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign mapped = paddr == dxm_pkg::OFF_CTRL ||
                  paddr == dxm_pkg::OFF_FIRST ||
                  paddr == dxm_pkg::OFF_SECOND ||
                  paddr == dxm_pkg::OFF_STATUS;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = st_reg.rdata;
  assign read_allowed = st_reg.acnt == 8'h00 && !st_reg.in_sr;

  always_comb
  begin
    status = '0;
    status[dxm_pkg::S_BUSY] = st_reg.st != ST_IDLE;
    status[dxm_pkg::S_REJECT] = st_reg.reject;
    status[dxm_pkg::S_SECOND_OK] = st_reg.second_ok;
    status[dxm_pkg::S_ALIGN_WAIT] = st_reg.acnt != 8'h00;
    status[dxm_pkg::S_IN_SR] = st_reg.in_sr;
    first_w = pwdata[dxm_pkg::AW-1:0];
    if (!X8)
    begin
      first_w[dxm_pkg::B_XSTROBE] = 1'b0;
      first_w[dxm_pkg::B_TOP] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.cmd_n = CMD_DESEL;
    if (setup)
    begin
      case (paddr)
        dxm_pkg::OFF_FIRST: st_next.rdata = 32'(st_reg.first);
        dxm_pkg::OFF_SECOND:
          st_next.rdata = 32'(st_reg.ht_sr) << dxm_pkg::B_HT_SR;
        dxm_pkg::OFF_STATUS: st_next.rdata = status;
        default: st_next.rdata = '0;
      endcase
    end
    if (st_reg.acnt != 8'h00)
      st_next.acnt = st_reg.acnt - 8'h01;
    if (wr && paddr == dxm_pkg::OFF_FIRST)
      st_next.first = first_w;
    if (wr && paddr == dxm_pkg::OFF_SECOND)
      st_next.ht_sr = pwdata[dxm_pkg::B_HT_SR];
    case (st_reg.st)
      ST_IDLE:
      begin
        if (wr && paddr == dxm_pkg::OFF_CTRL)
        begin
          st_next.op = pwdata[1:0];
          st_next.reject = 1'b0;
          case (pwdata[1:0])
            dxm_pkg::OP_SR_EXIT:
              if (st_reg.in_sr)
                st_next.st = ST_CMD;
              else
                st_next.reject = 1'b1;
            default:
              if (all_banks_idle && !st_reg.in_sr)
                st_next.st = ST_CMD;
              else
                st_next.reject = 1'b1;
          endcase
        end
      end
      ST_CMD:
      begin
        st_next.st = ST_WAIT;
        st_next.wcnt = MODE_SET_CYCLE_TIME_L;
        st_next.ba = '0;
        st_next.addr = '0;
        case (st_reg.op)
          dxm_pkg::OP_FIRST:
          begin
            st_next.cmd_n = CMD_MRS;
            st_next.ba = dxm_pkg::BA_FIRST;
            st_next.addr = st_reg.first;
            if (st_reg.cal_follow)
            begin
              st_next.addr[dxm_pkg::B_CAL_HI:dxm_pkg::B_CAL_LO] =
                dxm_pkg::CAL_EXIT;
              st_next.first = st_next.addr;
              st_next.cal_follow = 1'b0;
            end
            else if (st_reg.first[dxm_pkg::B_CAL_HI:dxm_pkg::B_CAL_LO] ==
                     dxm_pkg::CAL_DEFAULT)
              st_next.cal_follow = 1'b1;
            if (!st_reg.first[dxm_pkg::B_ALIGN_OFF])
              st_next.acnt = ALIGN_L;
          end
          dxm_pkg::OP_SECOND:
          begin
            st_next.cmd_n = CMD_MRS;
            st_next.ba = dxm_pkg::BA_SECOND;
            st_next.addr[dxm_pkg::B_HT_SR] = st_reg.ht_sr;
            st_next.second_ok = 1'b1;
          end
          dxm_pkg::OP_SR_ENTER:
          begin
            st_next.cmd_n = CMD_REF;
            st_next.cke = 1'b0;
            st_next.in_sr = 1'b1;
          end
          default:
          begin
            st_next.cke = 1'b1;
            st_next.in_sr = 1'b0;
            if (!st_reg.first[dxm_pkg::B_ALIGN_OFF])
              st_next.acnt = ALIGN_L;
          end
        endcase
      end
      ST_WAIT:
      begin
        if (st_reg.wcnt != 4'h0)
          st_next.wcnt = st_reg.wcnt - 4'h1;
        else if (st_reg.cal_follow)
          st_next.st = ST_CMD;
        else
          st_next.st = ST_IDLE;
      end
      default: st_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.cke <= 1'b1;
      st_reg.cmd_n <= CMD_DESEL;
    end
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // Link drive
  // ---------------------------------------------------------------
  assign link.cke = st_reg.cke;
  assign link.cs_n = st_reg.cmd_n[3];
  assign link.ras_n = st_reg.cmd_n[2];
  assign link.cas_n = st_reg.cmd_n[1];
  assign link.we_n = st_reg.cmd_n[0];
  assign link.ba = st_reg.ba;
  assign link.addr = st_reg.addr;
endmodule : dxm_ctl

// ### hw/dxm_dev.sv
// Device end: decodes mode set commands and holds both extended settings.
// Assumes the controller keeps bank and timing preconditions.
`timescale 1ns/10ps
module dxm_dev #(
  parameter bit X8 = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  dxm_if.dev link,
  output logic drive_reduced,
  output logic outputs_off,
  output logic extra_read_strobe,
  output logic strobe_n_off,
  output logic cal_default,
  output logic [2:0] posted_cas_delay,
  output logic top_addr_bit,
  output logic clock_align_on,
  output logic high_temp_self_refresh_rate,
  output logic in_self_refresh,
  output logic first_valid,
  output logic second_valid
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cke_q;
    logic [dxm_pkg::AW-1:0] first;
    logic ht_sr;
    logic in_sr;
    logic first_ok;
    logic second_ok;
  } dxm_dev_t;
  dxm_dev_t st_reg, st_next;
  logic mrs;
  logic refresh;
  logic [2:0] pcd_in;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.cke_q = link.cke;
    mrs = st_reg.cke_q && link.cke && !link.cs_n && !link.ras_n &&
          !link.cas_n && !link.we_n;
    refresh = !link.cs_n && !link.ras_n && !link.cas_n && link.we_n;
    pcd_in = link.addr[dxm_pkg::B_PCD_HI:dxm_pkg::B_PCD_LO];
    if (mrs && link.ba == dxm_pkg::BA_FIRST)
    begin
      st_next.first = link.addr;
      if (pcd_in > dxm_pkg::PCD_MAX)
        st_next.first[dxm_pkg::B_PCD_HI:dxm_pkg::B_PCD_LO] =
          st_reg.first[dxm_pkg::B_PCD_HI:dxm_pkg::B_PCD_LO];
      if (!X8)
        st_next.first[dxm_pkg::B_TOP] = 1'b0;
      st_next.first_ok = 1'b1;
    end
    if (mrs && link.ba == dxm_pkg::BA_SECOND)
    begin
      st_next.ht_sr = link.addr[dxm_pkg::B_HT_SR];
      st_next.second_ok = 1'b1;
    end
    if (st_reg.cke_q && !link.cke && refresh)
      st_next.in_sr = 1'b1;
    else if (!st_reg.cke_q && link.cke)
      st_next.in_sr = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // Setting outputs
  // ---------------------------------------------------------------
  assign drive_reduced = st_reg.first[dxm_pkg::B_DRIVE];
  assign outputs_off = st_reg.first[dxm_pkg::B_OUT_OFF];
  assign extra_read_strobe = st_reg.first[dxm_pkg::B_XSTROBE];
  assign strobe_n_off = st_reg.first[dxm_pkg::B_STROBE_N];
  assign cal_default = st_reg.first[dxm_pkg::B_CAL_HI:dxm_pkg::B_CAL_LO]
                       == dxm_pkg::CAL_DEFAULT;
  assign posted_cas_delay =
    st_reg.first[dxm_pkg::B_PCD_HI:dxm_pkg::B_PCD_LO];
  assign top_addr_bit = st_reg.first[dxm_pkg::B_TOP];
  assign clock_align_on = !st_reg.first[dxm_pkg::B_ALIGN_OFF] &&
                          !st_reg.in_sr;
  assign high_temp_self_refresh_rate = st_reg.ht_sr;
  assign in_self_refresh = st_reg.in_sr;
  assign first_valid = st_reg.first_ok;
  assign second_valid = st_reg.second_ok;
endmodule : dxm_dev

// ### hw/dxm_if.sv
// Command and address link between controller and device.
// Assumes both ends run on the same pclk.
`timescale 1ns/10ps
interface dxm_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [dxm_pkg::AW-1:0] addr;
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : dxm_if

// ### hw/dxm_pkg.sv
// Constants shared by both ends of the extended mode setup link.
// Assumes one clock, pclk, shared by device and controller.
package dxm_pkg;
  // ---------------------------------------------------------------
  // Link encoding
  // ---------------------------------------------------------------
  localparam int AW = 14;
  localparam logic [1:0] BA_FIRST = 2'h1;
  localparam logic [1:0] BA_SECOND = 2'h2;
  localparam int B_ALIGN_OFF = 0;
  localparam int B_DRIVE = 1;
  localparam int B_PCD_LO = 3;
  localparam int B_PCD_HI = 5;
  localparam int B_CAL_LO = 7;
  localparam int B_CAL_HI = 9;
  localparam int B_STROBE_N = 10;
  localparam int B_XSTROBE = 11;
  localparam int B_OUT_OFF = 12;
  localparam int B_TOP = 13;
  localparam int B_HT_SR = 7;
  localparam logic [2:0] CAL_EXIT = 3'h0;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;
  localparam logic [2:0] PCD_MAX = 3'h5;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int MODE_SET_CYCLE_TIME_CK = 2;
  localparam int ALIGN_CK = 200;
  // ---------------------------------------------------------------
  // Controller register map (APB byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FIRST = 8'h04;
  localparam logic [7:0] OFF_SECOND = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [1:0] OP_FIRST = 2'h0;
  localparam logic [1:0] OP_SECOND = 2'h1;
  localparam logic [1:0] OP_SR_ENTER = 2'h2;
  localparam logic [1:0] OP_SR_EXIT = 2'h3;
  localparam int S_BUSY = 0;
  localparam int S_REJECT = 1;
  localparam int S_SECOND_OK = 2;
  localparam int S_ALIGN_WAIT = 3;
  localparam int S_IN_SR = 4;
endpackage : dxm_pkg

// ### verif/dxm_assertions.sv
// Link checker for the extended mode setup link.
// Assumes one pclk domain with active low presetn.
`timescale 1ns/10ps
module dxm_assertions #(
  parameter bit X8 = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [dxm_pkg::AW-1:0] addr
);
  // ---------------------------------------------------------------
  // Link rules
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mrs = !cs_n && !ras_n && !cas_n && !we_n;
  sequence s_first(v);
    mrs && ba == dxm_pkg::BA_FIRST && addr[9:7] == v;
  endsequence
  chk_mrs_cke: assert property (mrs |-> cke && $past(cke))
    else $error("mode set without clock enable");
  chk_mrs_spacing: assert property (mrs |=> cs_n [*2])
    else $error("command inside mode set wait");
  chk_mrs_select: assert property (mrs |-> ba inside {2'h1, 2'h2})
    else $error("mode set to unknown setting");
  chk_second_zero: assert property (
    mrs && ba == dxm_pkg::BA_SECOND |-> (addr & 14'h3f7f) == 14'h0)
    else $error("reserved second setting bit set");
  chk_cal_exit: assert property (s_first(3'h7) |-> ##[3:6] s_first(3'h0))
    else $error("calibration not exited");
  chk_x16_bits: assert property (
    mrs && ba == dxm_pkg::BA_FIRST && !X8 |-> !addr[11] && !addr[13])
    else $error("x8 only bit set on x16");
  chk_sr_entry: assert property (
    $fell(cke) |-> !cs_n && !ras_n && !cas_n && we_n)
    else $error("clock enable fell without refresh");
  chk_sr_exit: assert property (
    $rose(cke) |-> cs_n || (ras_n && cas_n && we_n))
    else $error("self refresh exit not a no-op");
endmodule : dxm_assertions

// ### verif/tb_ddr2_extended_mode_setup.sv
// Testbench joining controller and device over the link.
// Assumes the x16 build; drives APB and all_banks_idle.
`timescale 1ns/10ps
module tb_ddr2_extended_mode_setup;
  // ---------------------------------------------------------------
  // Bench
  // ---------------------------------------------------------------
  localparam int ALIGN = 40;
  logic pclk, presetn, psel, penable, pwrite, idle, pready, pslverr;
  logic rd_ok, err, drv, off, xs, sn, cal, tab, ca, ht, sr, fv, sv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] pcd;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  dxm_if link ();
  dxm_ctl #(.X8(1'b0), .ALIGN(ALIGN)) u_dxm_ctl (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .all_banks_idle(idle), .read_allowed(rd_ok),
    .link(link));
  dxm_dev #(.X8(1'b0)) u_dxm_dev (.pclk(pclk), .presetn(presetn),
    .link(link), .drive_reduced(drv), .outputs_off(off),
    .extra_read_strobe(xs), .strobe_n_off(sn), .cal_default(cal),
    .posted_cas_delay(pcd), .top_addr_bit(tab), .clock_align_on(ca),
    .high_temp_self_refresh_rate(ht), .in_self_refresh(sr),
    .first_valid(fv), .second_valid(sv));
  dxm_assertions #(.X8(1'b0)) u_dxm_assertions (.pclk(pclk),
    .presetn(presetn), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .ba(link.ba), .addr(link.addr));
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [31:0] dv();
    return {18'h0, drv, off, xs, sn, cal, tab, pcd, ca, ht, sr, fv, sv};
  endfunction : dv
  task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic op(input logic [1:0] o, input logic [31:0] v);
    if (o == dxm_pkg::OP_FIRST)
      apb(1'b1, dxm_pkg::OFF_FIRST, v);
    if (o == dxm_pkg::OP_SECOND)
      apb(1'b1, dxm_pkg::OFF_SECOND, v);
    apb(1'b1, dxm_pkg::OFF_CTRL, {30'h0, o});
    do apb(1'b0, dxm_pkg::OFF_STATUS, 32'h0); while (q[0] !== 1'b0);
    repeat (4) @(posedge pclk);
  endtask : op
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_first();
    op(dxm_pkg::OP_FIRST, 32'h3c2a);
    chk("first", 32'h34b2, dv());
    chk("align wait", 32'h0, rd_ok);
    n = 0;
    while (rd_ok !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk("align span", 32'h1, n > ALIGN - 34 && n <= ALIGN);
  endtask : t_first
  task automatic t_delay();
    for (int i = 0; i < 8; i++)
    begin
      op(dxm_pkg::OP_FIRST, 32'(i * 8 + 1));
      chk("delay", 32'h2 | 32'((i < 6 ? i : 5) * 32), dv());
    end
  endtask : t_delay
  task automatic t_cal();
    op(dxm_pkg::OP_FIRST, 32'h380);
    chk("cal exit", 32'h12, dv());
  endtask : t_cal
  task automatic t_second();
    op(dxm_pkg::OP_SECOND, 32'hffff);
    chk("second", 32'h1b, dv());
    chk("second ok", 32'h1, q[dxm_pkg::S_SECOND_OK]);
    apb(1'b0, dxm_pkg::OFF_SECOND, 32'h0);
    chk("second reg", 32'h80, q);
    idle <= 1'b0;
    op(dxm_pkg::OP_SECOND, 32'h0);
    chk("reject", 32'h1, q[dxm_pkg::S_REJECT]);
    chk("kept", 32'h1b, dv());
    idle <= 1'b1;
  endtask : t_second
  task automatic t_sr();
    op(dxm_pkg::OP_SR_ENTER, 32'h0);
    chk("sr on", 32'h0f, dv());
    chk("sr read", 32'h0, rd_ok);
    op(dxm_pkg::OP_FIRST, 32'h2);
    chk("sr reject", 32'h0f, dv());
    apb(1'b0, dxm_pkg::OFF_FIRST, 32'h0);
    chk("first reg", 32'h2, q);
    op(dxm_pkg::OP_SR_EXIT, 32'h0);
    chk("sr off", 32'h1b, dv());
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, err);
  endtask : t_sr
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    idle = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset", 32'h10, dv());
    t_first();
    t_delay();
    t_cal();
    t_second();
    t_sr();
    end_of_test();
  end
endmodule : tb_ddr2_extended_mode_setup
